// *** sqr_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module sqr_host
    import sqr_pkg::*;
(
    input  wire logic       clock_in,
    output sqr_req_t        req_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    initial req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        if (a == ADDR_FAULT_TMO + SHADOW_OFFSET) d[3:0] = 4'h0;
        req_out = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge clock_in);
        #1;
        req_out = '0;
    endtask
    // Answer is registered on the same edge that samples the pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        #1;
        req_out = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_in);
        #1;
        req_out = '0;
        d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
    endtask
endmodule
`default_nettype wire

// *** sqr_pkg.sv ***
package sqr_pkg;

    localparam int          CLK_MHZ         = 250;
    localparam logic [7:0]  ADDR_FAULT_TMO  = 8'h0A;
    localparam logic [7:0]  ADDR_RAMP_12    = 8'h0B;
    localparam logic [7:0]  ADDR_RAMP_34    = 8'h0C;
    localparam logic [7:0]  ADDR_OC_THR     = 8'h0D;
    localparam logic [7:0]  ADDR_OC_CTRL    = 8'h0E;
    localparam logic [7:0]  ADDR_GATE_OC    = 8'h0F;
    localparam logic [7:0]  ADDR_PG_THR     = 8'h10;
    localparam logic [7:0]  ADDR_PD_LOCK    = 8'h13;
    localparam logic [7:0]  SHADOW_OFFSET   = 8'h20;
    localparam logic [7:0]  RESET_VALUE     = 8'h00;
    localparam int          LOCK_BIT        = 2;
    localparam int          NUM_REGS        = 8;

    // Times in microseconds, cycle counts derived from the clock rate
    localparam int          T_25US_US       = 25;
    localparam int          T_12M5_US       = 12500;
    localparam int          T_25M_US        = 25000;
    localparam int          T_50M_US        = 50000;
    localparam int          T_100M_US       = 100000;
    localparam int          T_200M_US       = 200000;
    localparam int          T_400M_US       = 400000;
    localparam int          T_1600M_US      = 1600000;
    localparam int          C_25US          = T_25US_US * CLK_MHZ;
    localparam int          C_12M5          = T_12M5_US * CLK_MHZ;
    localparam int          C_25M           = T_25M_US * CLK_MHZ;
    localparam int          C_50M           = T_50M_US * CLK_MHZ;
    localparam int          C_100M          = T_100M_US * CLK_MHZ;
    localparam int          C_200M          = T_200M_US * CLK_MHZ;
    localparam int          C_400M          = T_400M_US * CLK_MHZ;
    localparam int          C_1600M         = T_1600M_US * CLK_MHZ;

    // Thresholds in tenths of a percent
    localparam logic [9:0]  PCT_97_5        = 10'h3CF;
    localparam logic [9:0]  PCT_95_0        = 10'h3B6;
    localparam logic [9:0]  PCT_92_5        = 10'h39D;
    localparam logic [9:0]  PCT_90_0        = 10'h384;
    localparam logic [9:0]  PCT_87_5        = 10'h36B;

    typedef struct packed {
        logic [31:0]      fault_up_cycles;
        logic [31:0]      fault_down_cycles;
        logic [31:0]      oc_timeout_cycles;
        logic [31:0]      first_gate_delay_cycles;
        logic [3:0][3:0]  ramp_members;
        logic [3:0][9:0]  oc_threshold;
        logic [3:0][9:0]  pg_threshold;
        logic [3:0]       oc_monitor_en;
        logic             config_locked;
    } sqr_cfg_t;

    typedef struct packed {
        logic             wr_en;
        logic             rd_en;
        logic [7:0]       addr;
        logic [7:0]       wdata;
    } sqr_req_t;

endpackage

// *** sqr_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Fault-timer bits 7:6 select the power-up fault timeout of 25, 50, 100 or 200 ms.
// - Fault-timer bits 5:4 select the power-down fault timeout of 25, 50, 100 or 200 ms.
// - First ramp register bits 3:0 put rails one to four on ramp one, bits 7:4 on ramp two.
// - Second ramp register bits 3:0 put rails one to four on ramp three, bits 7:4 on ramp four.
// - Overcurrent thresholds are two bits per channel, codes giving 97.5, 95, 92.5 and 90 percent.
// - Overcurrent control bits 7:6 select a timeout of 12.5, 50, 100 or 200 ms.
// - Overcurrent control bits 5 to 2 enable monitoring on rails one to four, bits 1:0 unused.
// - Gate-delay bits 7:5 select the first gate delay from 25 us up to 1600 ms.
// - Gate-delay bits 3:0 show overcurrent on channels one to four, read-only at register address.
// - Power-good thresholds are two bits per channel, codes giving 95, 92.5, 90 and 87.5 percent.
// - A one in the lock bit of the pulldown/lock register locks the configuration registers.
module sqr_regs
    import sqr_pkg::*;
#(
    parameter int P_C_25US   = C_25US,
    parameter int P_C_12M5   = C_12M5,
    parameter int P_C_25M    = C_25M,
    parameter int P_C_50M    = C_50M,
    parameter int P_C_100M   = C_100M,
    parameter int P_C_200M   = C_200M,
    parameter int P_C_400M   = C_400M,
    parameter int P_C_1600M  = C_1600M
) (
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire sqr_req_t    req_in,
    output logic [7:0]       rdata_out,
    output logic             rvalid_out,
    input  wire logic        overcurrent_flag_one_in,
    input  wire logic        overcurrent_flag_two_in,
    input  wire logic        overcurrent_flag_three_in,
    input  wire logic        overcurrent_flag_four_in,
    output sqr_cfg_t         cfg_out
);

    logic             rst_meta_r;
    logic             rst_sync_r;
    logic [3:0]       oc_meta_r;
    logic [3:0]       oc_sync_r;
    logic [7:0]       reg_r     [NUM_REGS];
    logic [7:0]       reg_nxt   [NUM_REGS];
    logic [7:0]       shd_r     [NUM_REGS];
    logic [7:0]       shd_nxt   [NUM_REGS];
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic             rvalid_r;
    logic             rvalid_nxt;
    logic [7:0]       live_addr;
    logic             is_shadow;
    logic [3:0]       ridx;
    logic [2:0]       idx;
    logic             hit;
    logic             locked;
    logic [3:0]       oc_flags;

    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h8;
        if (a >= ADDR_FAULT_TMO && a <= ADDR_PG_THR) begin
            r = 4'(a - ADDR_FAULT_TMO);
        end else if (a == ADDR_PD_LOCK) begin
            r = 4'h7;
        end
        return r;
    endfunction

    // Bits the live register stores; reserved and unused bits read as zero
    function automatic logic [7:0] live_mask(input logic [2:0] i);
        logic [7:0] m;
        case (i)
            3'h0: m = 8'hF0;
            3'h4: m = 8'hFC;
            3'h5: m = 8'hE0;
            3'h7: m = 8'hFC;
            default: m = 8'hFF;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] fault_tmo(input logic [1:0] c);
        logic [31:0] v;
        case (c)
            2'h0: v = 32'(P_C_25M);
            2'h1: v = 32'(P_C_50M);
            2'h2: v = 32'(P_C_100M);
            default: v = 32'(P_C_200M);
        endcase
        return v;
    endfunction

    function automatic logic [9:0] oc_thr(input logic [1:0] c);
        logic [9:0] v;
        case (c)
            2'h0: v = PCT_97_5;
            2'h1: v = PCT_95_0;
            2'h2: v = PCT_92_5;
            default: v = PCT_90_0;
        endcase
        return v;
    endfunction

    function automatic logic [9:0] pg_thr(input logic [1:0] c);
        logic [9:0] v;
        case (c)
            2'h0: v = PCT_95_0;
            2'h1: v = PCT_92_5;
            2'h2: v = PCT_90_0;
            default: v = PCT_87_5;
        endcase
        return v;
    endfunction

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Overcurrent comparators are asynchronous to this clock
    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            oc_meta_r <= 4'h0;
            oc_sync_r <= 4'h0;
        end else begin
            oc_meta_r <= {overcurrent_flag_one_in, overcurrent_flag_two_in,
                          overcurrent_flag_three_in, overcurrent_flag_four_in};
            oc_sync_r <= oc_meta_r;
        end
    end

    assign locked    = reg_r[7][LOCK_BIT];
    assign is_shadow = (req_in.addr >= SHADOW_OFFSET);
    assign live_addr = is_shadow ? 8'(req_in.addr - SHADOW_OFFSET) : req_in.addr;
    // A call result cannot be bit-selected, so decode once into a net
    assign ridx      = reg_index(live_addr);
    assign hit       = ~ridx[3];
    assign idx       = ridx[2:0];
    // Disabled channels never report overcurrent
    assign oc_flags  = oc_sync_r & reg_r[4][5:2];

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            reg_nxt[i] = reg_r[i];
            shd_nxt[i] = shd_r[i];
        end
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        // Lock register stays writable so software can unlock again
        if (req_in.wr_en && hit && (!locked || idx == 3'h7)) begin
            if (is_shadow) begin
                // Shadow keeps the whole byte, reserved bits as the host wrote them
                shd_nxt[idx] = req_in.wdata;
            end else begin
                // Flag bits are never stored at the live address
                reg_nxt[idx] = req_in.wdata & live_mask(idx);
            end
        end
        if (req_in.rd_en) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 8'h00;
            if (hit && is_shadow) begin
                rdata_nxt = shd_r[idx];
            end else if (hit && idx == 3'h5) begin
                rdata_nxt = {reg_r[5][7:5], 1'b0, oc_flags};
            end else if (hit) begin
                rdata_nxt = reg_r[idx];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                reg_r[i] <= RESET_VALUE;
                shd_r[i] <= RESET_VALUE;
            end
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                reg_r[i] <= reg_nxt[i];
                shd_r[i] <= shd_nxt[i];
            end
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata_out  = rdata_r;
    assign rvalid_out = rvalid_r;

    always_comb begin
        cfg_out.fault_up_cycles   = fault_tmo(reg_r[0][7:6]);
        cfg_out.fault_down_cycles = fault_tmo(reg_r[0][5:4]);
        for (int r = 0; r < 4; r++) begin
            // Bit 0 of each nibble is rail one
            cfg_out.ramp_members[r] = (r < 2) ? reg_r[1][r*4 +: 4]
                                              : reg_r[2][(r-2)*4 +: 4];
        end
        for (int c = 0; c < 4; c++) begin
            // Same encoding for every channel, channel one included
            cfg_out.oc_threshold[c] = oc_thr(reg_r[3][c*2 +: 2]);
            cfg_out.pg_threshold[c] = pg_thr(reg_r[6][c*2 +: 2]);
            cfg_out.oc_monitor_en[c] = reg_r[4][5 - c];
        end
        case (reg_r[4][7:6])
            2'h0: cfg_out.oc_timeout_cycles = 32'(P_C_12M5);
            2'h1: cfg_out.oc_timeout_cycles = 32'(P_C_50M);
            2'h2: cfg_out.oc_timeout_cycles = 32'(P_C_100M);
            default: cfg_out.oc_timeout_cycles = 32'(P_C_200M);
        endcase
        case (reg_r[5][7:5])
            3'h0: cfg_out.first_gate_delay_cycles = 32'(P_C_25US);
            3'h1: cfg_out.first_gate_delay_cycles = 32'(P_C_12M5);
            3'h2: cfg_out.first_gate_delay_cycles = 32'(P_C_25M);
            3'h3: cfg_out.first_gate_delay_cycles = 32'(P_C_50M);
            3'h4: cfg_out.first_gate_delay_cycles = 32'(P_C_100M);
            3'h5: cfg_out.first_gate_delay_cycles = 32'(P_C_200M);
            3'h6: cfg_out.first_gate_delay_cycles = 32'(P_C_400M);
            default: cfg_out.first_gate_delay_cycles = 32'(P_C_1600M);
        endcase
        cfg_out.config_locked = locked;
    end

endmodule
`default_nettype wire

// *** sqr_regs_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module sqr_regs_assertions
    import sqr_pkg::*;
#(
    parameter int P_C_25US  = C_25US,
    parameter int P_C_12M5  = C_12M5,
    parameter int P_C_25M   = C_25M,
    parameter int P_C_50M   = C_50M,
    parameter int P_C_100M  = C_100M,
    parameter int P_C_200M  = C_200M,
    parameter int P_C_400M  = C_400M,
    parameter int P_C_1600M = C_1600M
) (
    input  wire logic     clock_in,
    input  wire logic     resetn_in,
    input  wire sqr_req_t req_in,
    input  wire logic     rvalid_out,
    input  wire sqr_cfg_t cfg_out
);
    localparam int FT[4] = '{P_C_25M, P_C_50M, P_C_100M, P_C_200M};
    localparam int OT[4] = '{P_C_12M5, P_C_50M, P_C_100M, P_C_200M};
    localparam int GT[8] = '{P_C_25US, P_C_12M5, P_C_25M, P_C_50M,
                             P_C_100M, P_C_200M, P_C_400M, P_C_1600M};
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // Unlocked write to one address
    sequence s_wr(a);
        req_in.wr_en && req_in.addr == a && !cfg_out.config_locked;
    endsequence
    a_read_answer: assert property (req_in.rd_en |=> rvalid_out)
        else $error("no read answer");
    a_no_stray: assert property (!req_in.rd_en |=> !rvalid_out)
        else $error("stray read answer");
    a_fault_up: assert property (s_wr(ADDR_FAULT_TMO) |=>
        cfg_out.fault_up_cycles == FT[$past(req_in.wdata[7:6])]) else $error("bad up timeout");
    a_fault_down: assert property (s_wr(ADDR_FAULT_TMO) |=>
        cfg_out.fault_down_cycles == FT[$past(req_in.wdata[5:4])]) else $error("bad down timeout");
    a_ramp_low: assert property (s_wr(ADDR_RAMP_12) |=>
        cfg_out.ramp_members[1:0] == $past(req_in.wdata)) else $error("bad ramp one two");
    a_ramp_high: assert property (s_wr(ADDR_RAMP_34) |=>
        cfg_out.ramp_members[3:2] == $past(req_in.wdata)) else $error("bad ramp three four");
    a_oc_control: assert property (s_wr(ADDR_OC_CTRL) |=>
        cfg_out.oc_timeout_cycles == OT[$past(req_in.wdata[7:6])]
        && cfg_out.oc_monitor_en[0] == $past(req_in.wdata[5])
        && cfg_out.oc_monitor_en[3] == $past(req_in.wdata[2])) else $error("bad oc control");
    a_gate_delay: assert property (s_wr(ADDR_GATE_OC) |=>
        cfg_out.first_gate_delay_cycles == GT[$past(req_in.wdata[7:5])]) else $error("bad gate");
    a_lock_hold: assert property (req_in.wr_en && cfg_out.config_locked &&
        req_in.addr inside {[8'h0A:8'h10]} |=> $stable(cfg_out)) else $error("locked change");
    a_lock_bit: assert property (req_in.wr_en && req_in.addr == ADDR_PD_LOCK |=>
        cfg_out.config_locked == $past(req_in.wdata[2])) else $error("bad lock bit");
endmodule
bind sqr_regs sqr_regs_assertions #(
    .P_C_25US(P_C_25US), .P_C_12M5(P_C_12M5), .P_C_25M(P_C_25M), .P_C_50M(P_C_50M),
    .P_C_100M(P_C_100M), .P_C_200M(P_C_200M), .P_C_400M(P_C_400M), .P_C_1600M(P_C_1600M)
) i_sqr_regs_assertions (
    .clock_in(clock_in), .resetn_in(resetn_in), .req_in(req_in),
    .rvalid_out(rvalid_out), .cfg_out(cfg_out)
);
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sqr_pkg::*;
    localparam int         FT[4]  = '{C_25M, C_50M, C_100M, C_200M};
    localparam int         OT[4]  = '{C_12M5, C_50M, C_100M, C_200M};
    localparam int         GT[8]  = '{C_25US, C_12M5, C_25M, C_50M,
                                      C_100M, C_200M, C_400M, C_1600M};
    localparam logic [9:0] OCT[4] = '{PCT_97_5, PCT_95_0, PCT_92_5, PCT_90_0};
    localparam logic [9:0] PGT[4] = '{PCT_95_0, PCT_92_5, PCT_90_0, PCT_87_5};
    logic       clock_in  = 1'b0;
    logic       resetn_in = 1'b0;
    logic [3:0] oc        = 4'h0;
    sqr_req_t   req;
    logic [7:0] rdata;
    logic       rvalid;
    sqr_cfg_t   cfg;
    int         num_errors  = 0;
    int         check_count = 0;
    always #2 clock_in = ~clock_in;
    sqr_host i_host (.clock_in(clock_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
    // Default cycle counts kept: the block only decodes them, nothing counts down
    sqr_regs i_dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .overcurrent_flag_one_in(oc[0]), .overcurrent_flag_two_in(oc[1]),
        .overcurrent_flag_three_in(oc[2]), .overcurrent_flag_four_in(oc[3]), .cfg_out(cfg)
    );
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk("read", e, d);
    endtask
    task automatic t_reset();
        for (int a = 10; a < 20; a++) rc(8'(a), 8'h00);
        rc(8'h00, 8'h00);
        chk("gate", GT[0], cfg.first_gate_delay_cycles);
        chk("up", FT[0], cfg.fault_up_cycles);
        chk("down", FT[0], cfg.fault_down_cycles);
        chk("octmo", OT[0], cfg.oc_timeout_cycles);
        chk("lock", 0, 32'(cfg.config_locked));
    endtask
    task automatic t_fault();
        for (int c = 0; c < 4; c++) begin
            i_host.wr(ADDR_FAULT_TMO, {2'(c), 2'(3 - c), 4'hF});
            chk("up", FT[c], cfg.fault_up_cycles);
            chk("down", FT[3 - c], cfg.fault_down_cycles);
            rc(ADDR_FAULT_TMO, {2'(c), 2'(3 - c), 4'h0});
        end
        i_host.wr(ADDR_FAULT_TMO + SHADOW_OFFSET, 8'h5F);
        rc(ADDR_FAULT_TMO + SHADOW_OFFSET, 8'h50);
    endtask
    task automatic t_ramp();
        i_host.wr(ADDR_RAMP_12, 8'hA5);
        i_host.wr(ADDR_RAMP_34, 8'h3C);
        chk("ramp", 32'h3CA5, 32'(cfg.ramp_members));
    endtask
    // Codes differ per channel so a swapped field shows
    task automatic t_thr();
        for (int c = 0; c < 4; c++) begin
            i_host.wr(ADDR_OC_THR, {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)});
            i_host.wr(ADDR_PG_THR, {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)});
            for (int k = 0; k < 4; k++) begin
                chk("octhr", 32'(OCT[(c + k) % 4]), 32'(cfg.oc_threshold[k]));
                chk("pgthr", 32'(PGT[(c + k) % 4]), 32'(cfg.pg_threshold[k]));
            end
        end
    endtask
    task automatic t_oc();
        logic [3:0] e;
        oc = 4'b0111;
        for (int g = 0; g < 8; g++) begin
            e = 4'(g + 5);
            i_host.wr(ADDR_OC_CTRL, {2'(g), e, 2'b11});
            chk("octmo", OT[g % 4], cfg.oc_timeout_cycles);
            chk("ocen", {e[0], e[1], e[2], e[3]}, 32'(cfg.oc_monitor_en));
            i_host.wr(ADDR_GATE_OC, {3'(g), 5'h1F});
            chk("gate", GT[g], cfg.first_gate_delay_cycles);
            rc(ADDR_GATE_OC, {3'(g), 1'b0, e & 4'b1110});
        end
    endtask
    task automatic t_lock();
        i_host.wr(ADDR_PD_LOCK, 8'h04);
        chk("lock", 1, 32'(cfg.config_locked));
        i_host.wr(ADDR_FAULT_TMO, 8'h00);
        rc(ADDR_FAULT_TMO, 8'hC0);
        chk("up", FT[3], cfg.fault_up_cycles);
        i_host.wr(ADDR_PD_LOCK, 8'h00);
        chk("lock", 0, 32'(cfg.config_locked));
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock_in);
        #1;
        resetn_in = 1'b1;
        // Internal reset copy needs two edges before a request is taken
        repeat (2) @(posedge clock_in);
        t_reset();
        t_fault();
        t_ramp();
        t_thr();
        t_oc();
        t_lock();
        end_of_test();
    end
endmodule
`default_nettype wire
